// [hw/dflp_consts.svh]
// Constants for the digital framer line port.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DFLP_CONSTS_SVH
`define DFLP_CONSTS_SVH

// Line rates in kHz
`define DFLP_T1_RATE_KHZ 16'd1544
`define DFLP_E1_RATE_KHZ 16'd2048

// Data-link rate step and select encodings (rate = step * select)
`define DFLP_DL_STEP_KHZ 16'd4
`define DFLP_DL_SEL_MIN 3'h1
`define DFLP_DL_SEL_MAX 3'h5

// Bits per frame and frames per multiframe
`define DFLP_T1_FRAME_BITS 9'd193
`define DFLP_E1_FRAME_BITS 9'd256
`define DFLP_T1_MF_FRAMES 5'd24
`define DFLP_E1_MF_FRAMES 5'd16

// Zero-suppression windows and violation spacing of the substitution codes
`define DFLP_E1_SUB_LEN 4'h4
`define DFLP_T1_SUB_LEN 4'h8
`define DFLP_T1_VIOL_GAP 3'h3

// Reset values
`define DFLP_RST_BIT 1'b0
`define DFLP_RST_CNT9 9'h000
`define DFLP_RST_CNT5 5'h00
`define DFLP_RST_ACC 16'h0000
`define DFLP_RST_LINE 8'h00

`endif

// [hw/dflp_pkg.sv]
// Types for the digital framer line port.
// Assumes the constants header sits in the include path.
`include "dflp_consts.svh"

package dflp_pkg;

   // Receive rails from the external physical layer device
   typedef struct packed {
      logic pos;
      logic neg;
   } dflp_rx_rails_t;

   // Transmit rails towards the external physical layer device
   typedef struct packed {
      logic first;
      logic second;
   } dflp_tx_rails_t;

   // Received data-link stream towards the external receiver
   typedef struct packed {
      logic clock;
      logic data;
   } dflp_datalink_t;

   // Gapped clock phase
   typedef enum logic [1:0] {
      DL_IDLE,
      DL_DATA,
      DL_HIGH
   } dflp_dl_state_t;

endpackage

// [hw/dflp_line_port.sv]
// Digital line-side port of a T1/E1 framer, used with the analog line interface bypassed.
// Assumes a single 10 MHz clock; the recovered line clock and all pins are synchronous inputs.
// Notes on behaviour
// - Single-rail select one: NRZ data on first output
// - Second output meaningless in single-rail format
// - Select zero: complementary dual-rail transmit pair
// - Gapped data-link clock at 4 to 20 kHz
// - Data-link output carries zero-suppression-removed data
// - Data-link bits change on recovered clock rise
// - Low sync input aligns transmit multiframe boundary
// - High sync input: multiframe timing runs freely
// - Receive split-phase pair or single-rail positive input
// - Recovered clock samples receive data, T1 or E1
`timescale 1ns/1ps
`default_nettype none
`include "dflp_consts.svh"

module dflp_line_port #(
   parameter int DL_ACC_W = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic line_clk_in,
   input wire logic e1_mode,
   input wire logic line_bypass,
   input wire logic nrz_sel,
   input wire logic rx_single_rail,
   input wire dflp_pkg::dflp_rx_rails_t rx_rails,
   input wire logic tx_data_in,
   input wire logic [2:0] dl_rate_sel,
   input wire logic tx_multiframe_sync_n,
   output logic tx_rail_first_out,
   output logic tx_rail_second_out,
   output logic datalink_gapped_clock,
   output logic datalink_serial_out,
   output logic rx_data_out,
   output logic tx_mf_boundary,
   output logic [4:0] tx_frame_num,
   output logic [8:0] tx_bit_num
);
   import dflp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Recovered line clock edge

   logic line_clk_q;
   logic line_rise;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         line_clk_q <= `DFLP_RST_BIT;
      else if (clk_en)
         line_clk_q <= line_clk_in;
   end

   assign line_rise = clk_en && line_clk_in && !line_clk_q;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit rails

   dflp_tx_rails_t tx_q;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         tx_q <= '0;
      else if (line_rise)
      begin
         if (!line_bypass)
            tx_q <= '0;
         else if (nrz_sel)
         begin
            tx_q.first <= tx_data_in;
            tx_q.second <= `DFLP_RST_BIT;
         end
         else
         begin
            tx_q.first <= tx_data_in;
            tx_q.second <= ~tx_data_in;
         end
      end
   end

   assign tx_rail_first_out = tx_q.first;
   assign tx_rail_second_out = tx_q.second;

   ////////////////////////////////////////////////////////////////////////////
   // Receive decode and zero-suppression removal

   logic mark_now;
   logic mark_pos;
   logic last_pos_q;
   logic viol_now;
   logic [7:0] line_q;
   logic [7:0] clear_mask;
   logic [2:0] since_viol_q;
   logic rx_bit_q;

   // Split-phase pair marks on either rail; single-rail uses the positive input only
   assign mark_now = rx_single_rail ? rx_rails.pos : (rx_rails.pos | rx_rails.neg);
   assign mark_pos = rx_rails.pos;
   assign viol_now = !rx_single_rail && mark_now && (mark_pos == last_pos_q);

   // Bits of the delay line that belong to a substitution code ending now
   function automatic logic [7:0] sub_mask(input logic e1, input logic viol, input logic [2:0] gap);
      logic [7:0] m;
      m = 8'h00;
      if (viol && e1)
         m = 8'h0F;
      else if (viol && (gap == `DFLP_T1_VIOL_GAP))
         m = 8'hFF;
      return m;
   endfunction

   assign clear_mask = sub_mask(e1_mode, viol_now, since_viol_q);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         last_pos_q <= `DFLP_RST_BIT;
         since_viol_q <= 3'h0;
         line_q <= `DFLP_RST_LINE;
         rx_bit_q <= `DFLP_RST_BIT;
      end
      else if (line_rise)
      begin
         if (mark_now && !rx_single_rail)
            last_pos_q <= mark_pos;
         if (viol_now)
            since_viol_q <= 3'h1;
         else if (since_viol_q != 3'h7 && since_viol_q != 3'h0)
            since_viol_q <= since_viol_q + 3'h1;
         line_q <= {line_q[6:0], mark_now} & ~clear_mask;
         rx_bit_q <= line_q[7] & ~clear_mask[7];
      end
   end

   assign rx_data_out = rx_bit_q;

   ////////////////////////////////////////////////////////////////////////////
   // Gapped data-link clock and serial output

   logic [DL_ACC_W-1:0] dl_acc_q;
   logic [DL_ACC_W-1:0] dl_step;
   logic [DL_ACC_W-1:0] line_khz;
   logic [DL_ACC_W-1:0] dl_sum;
   logic dl_take;
   logic dl_rate_ok;
   dflp_dl_state_t dl_state_q;
   dflp_datalink_t dl_q;

   assign dl_rate_ok = (dl_rate_sel >= `DFLP_DL_SEL_MIN) && (dl_rate_sel <= `DFLP_DL_SEL_MAX);
   assign dl_step = DL_ACC_W'(`DFLP_DL_STEP_KHZ * {13'h0000, dl_rate_sel});
   assign line_khz = e1_mode ? DL_ACC_W'(`DFLP_E1_RATE_KHZ) : DL_ACC_W'(`DFLP_T1_RATE_KHZ);
   assign dl_sum = dl_acc_q + dl_step;
   assign dl_take = line_rise && dl_rate_ok && (dl_sum >= line_khz);

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         dl_acc_q <= DL_ACC_W'(`DFLP_RST_ACC);
      else if (line_rise && dl_rate_ok)
         dl_acc_q <= dl_take ? dl_sum - line_khz : dl_sum;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         dl_state_q <= DL_IDLE;
         dl_q <= '0;
      end
      else if (line_rise)
      begin
         case (dl_state_q)
            DL_IDLE:
            begin
               dl_q.clock <= `DFLP_RST_BIT;
               if (dl_take)
               begin
                  dl_q.data <= rx_bit_q;
                  dl_state_q <= DL_DATA;
               end
            end
            DL_DATA:
            begin
               // Rising edge a full line period after the data settles
               dl_q.clock <= 1'b1;
               dl_state_q <= DL_HIGH;
            end
            DL_HIGH:
            begin
               dl_q.clock <= `DFLP_RST_BIT;
               if (dl_take)
               begin
                  dl_q.data <= rx_bit_q;
                  dl_state_q <= DL_DATA;
               end
               else
                  dl_state_q <= DL_IDLE;
            end
            default:
            begin
               dl_q.clock <= `DFLP_RST_BIT;
               dl_state_q <= DL_IDLE;
            end
         endcase
      end
   end

   assign datalink_gapped_clock = dl_q.clock;
   assign datalink_serial_out = dl_q.data;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit multiframe timing

   logic mf_sync_q;
   logic [8:0] bit_q;
   logic [4:0] frame_q;
   logic [8:0] frame_bits;
   logic [4:0] mf_frames;
   logic mf_bound_q;

   assign frame_bits = e1_mode ? `DFLP_E1_FRAME_BITS : `DFLP_T1_FRAME_BITS;
   assign mf_frames = e1_mode ? `DFLP_E1_MF_FRAMES : `DFLP_T1_MF_FRAMES;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         mf_sync_q <= 1'b1;
      else if (line_rise)
         mf_sync_q <= tx_multiframe_sync_n;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         bit_q <= `DFLP_RST_CNT9;
         frame_q <= `DFLP_RST_CNT5;
         mf_bound_q <= `DFLP_RST_BIT;
      end
      else if (line_rise)
      begin
         if (!mf_sync_q)
         begin
            bit_q <= `DFLP_RST_CNT9;
            frame_q <= `DFLP_RST_CNT5;
            mf_bound_q <= 1'b1;
         end
         else if (bit_q >= frame_bits - 9'd1)
         begin
            bit_q <= `DFLP_RST_CNT9;
            if (frame_q >= mf_frames - 5'd1)
            begin
               frame_q <= `DFLP_RST_CNT5;
               mf_bound_q <= 1'b1;
            end
            else
            begin
               frame_q <= frame_q + 5'd1;
               mf_bound_q <= `DFLP_RST_BIT;
            end
         end
         else
         begin
            bit_q <= bit_q + 9'd1;
            mf_bound_q <= `DFLP_RST_BIT;
         end
      end
   end

   assign tx_mf_boundary = mf_bound_q;
   assign tx_frame_num = frame_q;
   assign tx_bit_num = bit_q;

endmodule

`default_nettype wire

// [verification/dflp_line_port_properties.sv]
// Checker for the digital framer line port.
// Assumes all pins are sampled on sys_clk; bound to the line port module above.
`timescale 1ns/1ps
`default_nettype none
module dflp_line_port_properties (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic line_clk_in,
   input wire logic e1_mode,
   input wire logic line_bypass,
   input wire logic nrz_sel,
   input wire logic tx_data_in,
   input wire logic tx_multiframe_sync_n,
   input wire logic tx_rail_first_out,
   input wire logic tx_rail_second_out,
   input wire logic datalink_gapped_clock,
   input wire logic datalink_serial_out,
   input wire logic tx_mf_boundary,
   input wire logic [4:0] tx_frame_num,
   input wire logic [8:0] tx_bit_num
);
   logic line_q;
   logic sync_q;
   wire logic le = clk_en && line_clk_in && !line_q;
   // Expected successor of the bit counter: last bit of a frame wraps to zero
   wire logic [8:0] next_bit = (tx_bit_num == (e1_mode ? 9'h0FF : 9'h0C0)) ? 9'h000 : tx_bit_num + 9'h001;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         line_q <= 1'b0;
      else if (clk_en)
         line_q <= line_clk_in;
   end
   // Mirror of the registered sync input
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         sync_q <= 1'b1;
      else if (le)
         sync_q <= tx_multiframe_sync_n;
   end
   sequence s_sync_low;
      le && !sync_q;
   endsequence
   sequence s_free_edge;
      le && sync_q;
   endsequence
   chk_tx_first_data: assert property (le && line_bypass |=> tx_rail_first_out == $past(tx_data_in))
      else $error("first rail does not follow transmit data");
   chk_tx_pair_compl: assert property (le && line_bypass && !nrz_sel |=> tx_rail_second_out != tx_rail_first_out)
      else $error("dual rails not complementary");
   chk_tx_bypass_off: assert property (le && !line_bypass |=> !tx_rail_first_out && !tx_rail_second_out)
      else $error("rails driven without bypass");
   chk_dl_data_hold: assert property (!le |=> $stable(datalink_serial_out))
      else $error("data-link bit moved off a line edge");
   chk_dl_clock_edge: assert property ($rose(datalink_gapped_clock) |-> $past(le) && $stable(datalink_serial_out))
      else $error("gapped clock rose badly");
   chk_mf_align: assert property (s_sync_low |=> tx_mf_boundary && tx_frame_num == 5'h00 && tx_bit_num == 9'h000)
      else $error("sync low did not restart multiframe");
   chk_mf_free_run: assert property (s_free_edge |=> tx_bit_num == $past(next_bit))
      else $error("bit counter step wrong");
   chk_mf_boundary: assert property (tx_mf_boundary |-> tx_frame_num == 5'h00 && tx_bit_num == 9'h000)
      else $error("boundary away from frame zero");
endmodule
bind dflp_line_port dflp_line_port_properties i_chk (.*);
`default_nettype wire

// [verification/dflp_line_phy_model.sv]
// External physical layer device and data-link receiver.
// Assumes sys_clk at 10 MHz; the line clock is divided from it.
`timescale 1ns/1ps
`default_nettype none
module dflp_line_phy_model (
   input wire logic sys_clk,
   input wire logic line_ones,
   input wire logic line_viol,
   input wire logic single_rail,
   input wire logic dl_clock,
   input wire logic dl_data,
   output var logic line_clk,
   output var dflp_pkg::dflp_rx_rails_t rx_rails,
   output var logic dl_bit,
   output var int dl_count
);
   logic [1:0] div_q = 2'h0;
   logic mark_q = 1'b0;
   initial
   begin
      line_clk = 1'b0;
      rx_rails = 2'h0;
      dl_bit = 1'b0;
      dl_count = 0;
   end
   // Line clock, new bit after each fall; split-phase marks alternate rails, single-rail marks all go on the positive rail
   always @(posedge sys_clk)
   begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2)
         line_clk <= !line_clk;
      if (div_q == 2'h2 && line_clk)
      begin
         // A violation mark repeats the previous polarity and keeps the alternation
         mark_q <= mark_q ^ (line_ones && !line_viol);
         rx_rails.pos <= single_rail ? line_ones : line_ones && (line_viol ? mark_q : !mark_q);
         rx_rails.neg <= single_rail ? !rx_rails.neg : line_ones && (line_viol ? !mark_q : mark_q);
      end
   end
   always @(posedge dl_clock)
   begin
      dl_bit <= dl_data;
      dl_count <= dl_count + 1;
   end
endmodule
`default_nettype wire

// [verification/dflp_line_port_tb_top.sv]
// Self-checking bench for the digital framer line port.
// Assumes the phy model makes the line clock and receive rails.
`timescale 1ns/1ps
`default_nettype none
module dflp_line_port_tb_top;
   import dflp_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst, clk_en, e1_mode, line_bypass, nrz_sel, rx_single_rail, tx_data_in, sync_n, line_ones, line_viol;
   logic [2:0] dl_rate_sel;
   logic line_clk, tx_a, tx_b, dl_clk, dl_out, rx_out, mf_b, dl_bit;
   logic [4:0] frame;
   logic [8:0] bitn;
   dflp_rx_rails_t rails;
   int dl_count, miscompares = 0, comparisons = 0, cycles = 0;
   always #50 sys_clk = !sys_clk;
   dflp_line_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .line_clk_in(line_clk),
      .e1_mode(e1_mode), .line_bypass(line_bypass), .nrz_sel(nrz_sel), .rx_single_rail(rx_single_rail),
      .rx_rails(rails), .tx_data_in(tx_data_in), .dl_rate_sel(dl_rate_sel), .tx_multiframe_sync_n(sync_n),
      .tx_rail_first_out(tx_a), .tx_rail_second_out(tx_b), .datalink_gapped_clock(dl_clk),
      .datalink_serial_out(dl_out), .rx_data_out(rx_out), .tx_mf_boundary(mf_b), .tx_frame_num(frame),
      .tx_bit_num(bitn));
   dflp_line_phy_model i_phy (.sys_clk(sys_clk), .line_ones(line_ones), .single_rail(rx_single_rail),
      .dl_clock(dl_clk), .dl_data(dl_out), .line_clk(line_clk), .rx_rails(rails), .dl_bit(dl_bit),
      .dl_count(dl_count), .line_viol(line_viol));
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge line_clk);
      @(negedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic do_reset(input logic e1);
      @(negedge sys_clk);
      sys_rst = 1'b1;
      e1_mode = e1;
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
   endtask
   task automatic run_tx();
      for (int m = 0; m < 3; m++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            @(negedge line_clk);
            @(negedge sys_clk);
            nrz_sel = (m == 0);
            line_bypass = (m != 2);
            tx_data_in = i[0] ^ i[1];
            edges(1);
            check(tx_a, tx_data_in && m != 2);
            if (m == 1) check(tx_b, !tx_data_in);
         end
      end
   endtask
   task automatic run_mf(input logic e1);
      int k;
      logic [13:0] held;
      do_reset(e1);
      @(negedge line_clk);
      @(negedge sys_clk);
      sync_n = 1'b0;
      @(negedge line_clk);
      @(negedge sys_clk);
      sync_n = 1'b1;
      edges(1);
      check({mf_b, frame, bitn}, {1'b1, 14'h0000});
      k = 0;
      do
      begin
         edges(1);
         k++;
      end
      while (mf_b !== 1'b1 && k < 5000);
      check(k[15:0], e1 ? 16'h1000 : 16'h1218);
      held = {frame, bitn};
      clk_en = 1'b0;
      repeat (30) @(negedge sys_clk);
      check({frame, bitn}, held);
      clk_en = 1'b1;
   endtask
   task automatic run_dl();
      int c0;
      do_reset(1'b1);
      for (int s = 0; s < 6; s++)
      begin
         @(negedge sys_clk);
         dl_rate_sel = s[2:0];
         rx_single_rail = s[0];
         edges(16);
         c0 = dl_count;
         edges(512);
         check(rx_out, 1'b1);
         check((dl_count - c0 - s) ** 2 <= (s != 0), 1'b1);
         if (s > 1) check(dl_bit, 1'b1);
      end
      line_ones = 1'b0;
      edges(16);
      check(rx_out, 1'b0);
   endtask
   // Split-phase E1 run of four zeros, line_viol raised on the fourth with no mark driven, must come out as four zeros
   task automatic run_zcs();
      int ones;
      ones = 0;
      rx_single_rail = 1'b0;
      line_ones = 1'b1;
      edges(20);
      for (int j = 0; j < 40; j++)
      begin
         @(negedge line_clk);
         @(negedge sys_clk);
         line_ones = (j < 20 || j > 23);
         line_viol = (j == 23);
         ones += rx_out;
      end
      line_viol = 1'b0;
      check(ones[15:0], 16'h0024);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial
   begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      e1_mode = 1'b1;
      line_bypass = 1'b1;
      nrz_sel = 1'b1;
      rx_single_rail = 1'b0;
      tx_data_in = 1'b0;
      dl_rate_sel = 3'h1;
      sync_n = 1'b1;
      line_ones = 1'b1;
      line_viol = 1'b0;
      do_reset(1'b1);
      run_tx();
      run_mf(1'b1);
      run_mf(1'b0);
      run_dl();
      run_zcs();
      tally_and_finish();
   end
endmodule
`default_nettype wire
